// ===== include/alo_defines.svh
// Constants for the accumulator logical-operation datapath
// Summary of operation
// - Word OR: low accumulator half with memory word
// - Word OR sets zero flag from result
// - Long OR: full accumulator with pair/constant
// - Long OR sets zero and sign flags
// - Bit-run OR with 1 to 32 bits
// - Bit-run OR sets zero and sign flags
// - Stack OR, then pop stack up one level
// - Stack OR sets zero and sign flags
// - Word XOR: low accumulator half with word
// - Word XOR sets zero flag from result
// - Long XOR: full accumulator with pair/constant
// - Long XOR sets zero and sign flags
// - Bit-run XOR, global I/O bits also allowed
// - Bit-run XOR sets zero and sign flags
// - Flags hold until next writer of them
`ifndef ALO_DEFINES_SVH
`define ALO_DEFINES_SVH
`define ALO_ACC_W       32
`define ALO_WORD_W      16
`define ALO_CNT_W       6
`define ALO_STACK_DEPTH 8
`define ALO_ACC_RESET   32'h0000_0000
`define ALO_SIGN_BIT    31
`endif

// ===== include/alo_pkg.sv
// Types shared by the accumulator logical-operation datapath
package alo_pkg;
    // Operation selector driven by the instruction sequencer
    typedef enum logic [3:0] {
        ALO_OP_LOAD,
        ALO_OP_PUSH,
        ALO_OP_OR_WORD,
        ALO_OP_XOR_WORD,
        ALO_OP_OR_LONG,
        ALO_OP_XOR_LONG,
        ALO_OP_OR_BITS,
        ALO_OP_XOR_BITS,
        ALO_OP_OR_STACK
    } alo_op_t;
endpackage

// ===== design/alo_bitrun_mask.sv
// Bit-run gate: keeps the first count bits of a run, clears the rest
`timescale 1ns/100ps
`include "alo_defines.svh"
module alo_bitrun_mask (
    input  wire logic [`ALO_ACC_W-1:0] run_bits,
    input  wire logic [`ALO_CNT_W-1:0] run_count,
    output logic      [`ALO_ACC_W-1:0] run_value
);
    // One gate per bit position: bit i survives only when i < count
    genvar gi;
    generate
        for (gi = 0; gi < `ALO_ACC_W; gi++) begin : g_bit
            assign run_value[gi] = run_bits[gi] & (run_count > `ALO_CNT_W'(gi));
        end
    endgenerate
endmodule

// ===== design/alo_top.sv
// Accumulator OR / XOR datapath with status flags and accumulator stack
`timescale 1ns/100ps
`include "alo_defines.svh"
module alo_top (
    input  wire logic                    sys_clk,
    input  wire logic                    resetn,
    input  wire logic                    ce,
    input  wire logic                    cmd_valid,
    input  wire alo_pkg::alo_op_t        cmd_op,
    input  wire logic [`ALO_ACC_W-1:0]   cmd_operand,
    input  wire logic [`ALO_ACC_W-1:0]   bit_local_data,
    input  wire logic [`ALO_ACC_W-1:0]   global_io_bits,
    input  wire logic                    bit_src_global,
    input  wire logic [`ALO_CNT_W-1:0]   bit_count,
    output logic      [`ALO_ACC_W-1:0]   acc_value,
    output logic      [`ALO_ACC_W-1:0]   stack_top,
    output logic                         result_zero_flag,
    output logic                         result_sign_flag,
    output logic                         op_done
);
    import alo_pkg::*;

    localparam int DEPTH = `ALO_STACK_DEPTH;

    // Operation is an exclusive OR rather than an inclusive OR
    function automatic logic op_is_xor(input alo_op_t op);
        return (op == ALO_OP_XOR_WORD) || (op == ALO_OP_XOR_LONG) || (op == ALO_OP_XOR_BITS);
    endfunction

    // Operation writes the sign flag as well as the zero flag
    function automatic logic op_sets_sign(input alo_op_t op);
        return (op == ALO_OP_OR_LONG) || (op == ALO_OP_XOR_LONG) ||
               (op == ALO_OP_OR_BITS) || (op == ALO_OP_XOR_BITS) ||
               (op == ALO_OP_OR_STACK);
    endfunction

    logic [`ALO_ACC_W-1:0] acc_reg;                 // Accumulator
    logic [`ALO_ACC_W-1:0] acc_next;                // Accumulator next value
    logic [`ALO_ACC_W-1:0] stack_reg [DEPTH];       // Stack levels, index 0 is top
    logic                  zero_reg;                // Zero status flag
    logic                  sign_reg;                // Sign status flag
    logic                  done_reg;                // Completion pulse

    wire logic                  fire     = ce & cmd_valid;         // Command taken
    wire logic                  is_xor   = op_is_xor(cmd_op);      // XOR family
    wire logic                  is_word  = (cmd_op == ALO_OP_OR_WORD) ||
                                           (cmd_op == ALO_OP_XOR_WORD);
    wire logic                  is_bits  = (cmd_op == ALO_OP_OR_BITS) ||
                                           (cmd_op == ALO_OP_XOR_BITS);
    wire logic                  is_long  = (cmd_op == ALO_OP_OR_LONG) ||
                                           (cmd_op == ALO_OP_XOR_LONG);
    wire logic                  do_pop   = (cmd_op == ALO_OP_OR_STACK);
    wire logic                  do_push  = (cmd_op == ALO_OP_PUSH);
    wire logic                  writes_z = is_word | is_long | is_bits | do_pop;
    // Global I/O space is a source only for the XOR bit run
    wire logic                  use_gx   = bit_src_global & (cmd_op == ALO_OP_XOR_BITS);
    wire logic [`ALO_ACC_W-1:0] run_src  = use_gx ? global_io_bits : bit_local_data;
    wire logic [`ALO_ACC_W-1:0] run_val;                                 // Masked bit run
    wire logic [`ALO_WORD_W-1:0] lo_acc  = acc_reg[`ALO_WORD_W-1:0];
    wire logic [`ALO_WORD_W-1:0] lo_opd  = cmd_operand[`ALO_WORD_W-1:0];
    wire logic [`ALO_WORD_W-1:0] word_or  = lo_acc | lo_opd;
    wire logic [`ALO_WORD_W-1:0] word_xor = lo_acc ^ lo_opd;
    wire logic [`ALO_ACC_W-1:0] wide_opd = is_bits ? run_val :
                                           (do_pop ? stack_reg[0] : cmd_operand);
    wire logic [`ALO_ACC_W-1:0] wide_res = is_xor ? (acc_reg ^ wide_opd)
                                                  : (acc_reg | wide_opd);
    wire logic [`ALO_WORD_W-1:0] word_res = is_xor ? word_xor : word_or;

    // Bit-run operand gating by count
    alo_bitrun_mask u_mask (
        .run_bits  (run_src),
        .run_count (bit_count),
        .run_value (run_val)
    );

    // Next accumulator value per operation; word forms keep the upper half
    always_comb begin
        acc_next = acc_reg;
        if (cmd_op == ALO_OP_LOAD) begin
            acc_next = cmd_operand;
        end else if (is_word) begin
            acc_next = {acc_reg[`ALO_ACC_W-1:`ALO_WORD_W], word_res};
        end else if (is_long | is_bits | do_pop) begin
            acc_next = wide_res;
        end
    end

    // Accumulator and completion pulse
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            acc_reg  <= `ALO_ACC_RESET;
            done_reg <= 1'b0;
        end else if (ce) begin
            done_reg <= cmd_valid;
            if (cmd_valid) begin
                acc_reg <= acc_next;
            end
        end
    end

    // Status flags: written only by operations that own them, else held
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            zero_reg <= 1'b0;
            sign_reg <= 1'b0;
        end else if (fire) begin
            if (writes_z) begin
                zero_reg <= (acc_next == `ALO_ACC_RESET);
            end
            if (op_sets_sign(cmd_op)) begin
                sign_reg <= acc_next[`ALO_SIGN_BIT];
            end
        end
    end

    // Stack levels: pop moves every level up, push moves every level down
    genvar gl;
    generate
        for (gl = 0; gl < DEPTH; gl++) begin : g_lvl
            wire logic [`ALO_ACC_W-1:0] below = (gl == DEPTH - 1) ? `ALO_ACC_RESET
                                                : stack_reg[(gl + 1) % DEPTH];
            wire logic [`ALO_ACC_W-1:0] above = (gl == 0) ? acc_reg : stack_reg[(gl + DEPTH - 1) % DEPTH];
            always_ff @(posedge sys_clk or negedge resetn) begin
                if (!resetn) begin
                    stack_reg[gl] <= `ALO_ACC_RESET;
                end else if (fire && do_pop) begin
                    stack_reg[gl] <= below;
                end else if (fire && do_push) begin
                    stack_reg[gl] <= above;
                end
            end
        end
    endgenerate

    assign acc_value        = acc_reg;
    assign stack_top        = stack_reg[0];
    assign result_zero_flag = zero_reg;
    assign result_sign_flag = sign_reg;
    assign op_done          = done_reg;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    property p_or_word;
        fire && cmd_op == ALO_OP_OR_WORD |=> acc_value ==
            {$past(acc_reg[31:16]), $past(acc_reg[15:0]) | $past(cmd_operand[15:0])};
    endproperty
    a_or_word: assert property (p_or_word) else $error("word OR result wrong");

    property p_word_zero;
        fire && is_word |=> result_zero_flag == (acc_value == 32'h0000_0000);
    endproperty
    a_word_zero: assert property (p_word_zero) else $error("word zero flag wrong");

    property p_or_long;
        fire && cmd_op == ALO_OP_OR_LONG |=> acc_value == ($past(acc_reg) | $past(cmd_operand));
    endproperty
    a_or_long: assert property (p_or_long) else $error("long OR result wrong");

    property p_wide_flags;
        fire && op_sets_sign(cmd_op) |=>
            result_sign_flag == acc_value[31] && result_zero_flag == (acc_value == 32'h0000_0000);
    endproperty
    a_wide_flags: assert property (p_wide_flags) else $error("wide flags wrong");

    property p_run_one;
        fire && cmd_op == ALO_OP_OR_BITS && bit_count == 6'h01 |=>
            acc_value == ($past(acc_reg) | {31'h0, $past(bit_local_data[0])});
    endproperty
    a_run_one: assert property (p_run_one) else $error("one-bit run wrong");

    property p_or_stack;
        fire && do_pop |=> acc_value == ($past(acc_reg) | $past(stack_reg[0]))
            && stack_top == $past(stack_reg[1]);
    endproperty
    a_or_stack: assert property (p_or_stack) else $error("stack OR or pop wrong");

    property p_xor_word;
        fire && cmd_op == ALO_OP_XOR_WORD |=> acc_value[15:0] ==
            ($past(acc_reg[15:0]) ^ $past(cmd_operand[15:0]));
    endproperty
    a_xor_word: assert property (p_xor_word) else $error("word XOR result wrong");

    property p_xor_long;
        fire && cmd_op == ALO_OP_XOR_LONG |=> acc_value == ($past(acc_reg) ^ $past(cmd_operand));
    endproperty
    a_xor_long: assert property (p_xor_long) else $error("long XOR result wrong");

    property p_xor_gx;
        fire && cmd_op == ALO_OP_XOR_BITS && bit_src_global && bit_count == 6'h20 |=>
            acc_value == ($past(acc_reg) ^ $past(global_io_bits));
    endproperty
    a_xor_gx: assert property (p_xor_gx) else $error("global XOR run wrong");

    property p_flag_hold;
        !(fire && writes_z) |=> $stable(result_zero_flag) && $stable(result_sign_flag);
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag changed without writer");

    property p_word_sign_hold;
        fire && is_word |=> $stable(result_sign_flag);
    endproperty
    a_word_sign_hold: assert property (p_word_sign_hold) else $error("word op wrote sign");

    property p_word_upper;
        fire && is_word |=> acc_value[31:16] == $past(acc_reg[31:16]);
    endproperty
    a_word_upper: assert property (p_word_upper) else $error("word op changed upper half");

    property p_xor_word_zero;
        fire && cmd_op == ALO_OP_XOR_WORD |=>
            result_zero_flag == (acc_value == 32'h0000_0000);
    endproperty
    a_xor_word_zero: assert property (p_xor_word_zero) else $error("word XOR zero wrong");

    property p_or_bits;
        fire && cmd_op == ALO_OP_OR_BITS && bit_count >= 6'h20 |=>
            acc_value == ($past(acc_reg) | $past(bit_local_data));
    endproperty
    a_or_bits: assert property (p_or_bits) else $error("full bit-run OR wrong");

    property p_bits_flags;
        fire && cmd_op == ALO_OP_OR_BITS |=> result_sign_flag == acc_value[31] &&
            result_zero_flag == (acc_value == 32'h0000_0000);
    endproperty
    a_bits_flags: assert property (p_bits_flags) else $error("bit-run OR flags wrong");

    property p_stack_flags;
        fire && do_pop |=> result_sign_flag == acc_value[31] &&
            result_zero_flag == (acc_value == 32'h0000_0000);
    endproperty
    a_stack_flags: assert property (p_stack_flags) else $error("stack OR flags wrong");

    property p_long_xor_flags;
        fire && cmd_op == ALO_OP_XOR_LONG |=> result_sign_flag == acc_value[31] &&
            result_zero_flag == (acc_value == 32'h0000_0000);
    endproperty
    a_long_xor_flags: assert property (p_long_xor_flags) else $error("long XOR flags wrong");

    property p_xor_bits_local;
        fire && cmd_op == ALO_OP_XOR_BITS && !bit_src_global && bit_count >= 6'h20 |=>
            acc_value == ($past(acc_reg) ^ $past(bit_local_data));
    endproperty
    a_xor_bits_local: assert property (p_xor_bits_local) else $error("local XOR run wrong");

    property p_xor_bits_flags;
        fire && cmd_op == ALO_OP_XOR_BITS |=> result_sign_flag == acc_value[31] &&
            result_zero_flag == (acc_value == 32'h0000_0000);
    endproperty
    a_xor_bits_flags: assert property (p_xor_bits_flags) else $error("XOR run flags wrong");
endmodule

// ===== test/alo_mem_model.sv
// Bit memory model: serves a run of discrete bits from local or global space
`timescale 1ns/100ps
module alo_mem_model (
    input  wire logic [10:0] bit_addr,
    output logic      [31:0] bit_local_data,
    output logic      [31:0] global_io_bits
);
    logic [2047:0] local_mem;   // Local relay and I/O bit space
    logic [2047:0] global_mem;  // Global I/O space, octal 0 to 3777
    // Unlike fixed patterns so a wrong source shows
    initial begin
        for (int i = 0; i < 2048; i++) begin
            local_mem[i] = ((i * 7) % 5) < 2;
            global_mem[i] = ((i * 13) % 3) == 0;
        end
    end
    // Run packed from the start address upward; past the end reads zero
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            bit_local_data[i] = (bit_addr + i < 2048) ? local_mem[bit_addr + i] : 1'b0;
            global_io_bits[i] = (bit_addr + i < 2048) ? global_mem[bit_addr + i] : 1'b0;
        end
    end
endmodule

// ===== test/testbench.sv
// Self-checking bench for the accumulator OR / XOR datapath
`timescale 1ns/100ps
module testbench;
    import alo_pkg::*;
    logic        sys_clk, resetn, ce, cmd_valid, bit_src_global;
    alo_op_t     cmd_op;
    logic [31:0] cmd_operand, bit_local_data, global_io_bits, acc_value, stack_top;
    logic [5:0]  bit_count;
    logic [10:0] bit_addr;
    logic        result_zero_flag, result_sign_flag, op_done;
    int          mismatches, tests_run;
    logic [15:0] lfsr_reg;   // Random source state
    logic [31:0] acc_m;      // Reference accumulator
    logic [31:0] stk_m[$];   // Reference stack, top at front
    logic        zf_m, sf_m, done_m;

    alo_top dut (.sys_clk(sys_clk), .resetn(resetn), .ce(ce), .cmd_valid(cmd_valid),
        .cmd_op(cmd_op), .cmd_operand(cmd_operand), .bit_local_data(bit_local_data),
        .global_io_bits(global_io_bits), .bit_src_global(bit_src_global),
        .bit_count(bit_count), .acc_value(acc_value), .stack_top(stack_top),
        .result_zero_flag(result_zero_flag), .result_sign_flag(result_sign_flag),
        .op_done(op_done));
    alo_mem_model mem (.bit_addr(bit_addr), .bit_local_data(bit_local_data),
        .global_io_bits(global_io_bits));

    // Two draws of the shift register give one 32-bit value
    function automatic logic [31:0] rnd();
        logic [31:0] v;
        lfsr_reg = {1'b0, lfsr_reg[15:1]} ^ (lfsr_reg[0] ? 16'hb400 : 16'h0000);
        v[15:0] = lfsr_reg;
        lfsr_reg = {1'b0, lfsr_reg[15:1]} ^ (lfsr_reg[0] ? 16'hb400 : 16'h0000);
        v[31:16] = lfsr_reg;
        return v;
    endfunction
    // Compare a one-bit status output against the reference
    task automatic chk_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Compare a 32-bit data output against the reference
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Reference state after reset: all clear, stack of eight zero levels
    task automatic reset_model();
        acc_m = '0;
        zf_m = 1'b0;
        sf_m = 1'b0;
        done_m = 1'b0;
        stk_m = {};
        repeat (8) stk_m.push_back('0);
    endtask
    // Drive one cycle, update the reference, compare after the edge
    task automatic step(input logic en, vld, input alo_op_t op, input logic [31:0] opnd,
                        input logic [5:0] cnt, input logic glb, input logic [10:0] adr);
        logic [31:0] run;
        ce = en;
        cmd_valid = vld;
        cmd_op = op;
        cmd_operand = opnd;
        bit_count = cnt;
        bit_src_global = glb;
        bit_addr = adr;
        #1;
        run = (op == ALO_OP_XOR_BITS && glb) ? global_io_bits : bit_local_data;
        run = run & ((cnt >= 32) ? 32'hffff_ffff : ((32'h1 << cnt) - 32'h1));
        if (en && resetn) begin
            done_m = vld;
            if (vld) begin
                case (op)
                    ALO_OP_LOAD:     acc_m = opnd;
                    ALO_OP_PUSH:     stk_m.push_front(acc_m);
                    ALO_OP_OR_WORD:  acc_m[15:0] = acc_m[15:0] | opnd[15:0];
                    ALO_OP_XOR_WORD: acc_m[15:0] = acc_m[15:0] ^ opnd[15:0];
                    ALO_OP_OR_LONG:  acc_m = acc_m | opnd;
                    ALO_OP_XOR_LONG: acc_m = acc_m ^ opnd;
                    ALO_OP_OR_BITS:  acc_m = acc_m | run;
                    ALO_OP_XOR_BITS: acc_m = acc_m ^ run;
                    default:         acc_m = acc_m | stk_m.pop_front();
                endcase
                if (op == ALO_OP_OR_STACK) stk_m.push_back('0);
                if (stk_m.size() > 8) stk_m.pop_back();
                if (op > ALO_OP_PUSH) zf_m = (acc_m == 0);
                if (op > ALO_OP_XOR_WORD) sf_m = acc_m[31];
            end
        end
        @(posedge sys_clk);
        #2;
        chk_word(acc_value, acc_m);
        chk_word(stack_top, stk_m[0]);
        chk_bit(result_zero_flag, zf_m);
        chk_bit(result_sign_flag, sf_m);
        chk_bit(op_done, done_m);
    endtask

    // Free-running 40 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // Hang guard, well beyond the few hundred cycles of the run
    initial begin
        #20000;
        mismatches++;
        summarize();
    end
    initial begin
        logic [31:0] r, v;
        resetn = 1'b0;
        mismatches = 0;
        tests_run = 0;
        lfsr_reg = 16'hdc36;
        reset_model();
        step(1'b0, 1'b0, ALO_OP_LOAD, 32'h0, 6'h0, 1'b0, 11'h0);
        repeat (5) @(posedge sys_clk);
        #2;
        resetn = 1'b1;
        // Sign, then zero from long XOR, then stack OR and pop
        step(1'b1, 1'b1, ALO_OP_LOAD, 32'h8000_1234, 6'h0, 1'b0, 11'h0);
        step(1'b1, 1'b1, ALO_OP_PUSH, 32'h8000_1234, 6'h0, 1'b0, 11'h0);
        step(1'b1, 1'b1, ALO_OP_OR_LONG, 32'h0, 6'h0, 1'b0, 11'h0);
        step(1'b1, 1'b1, ALO_OP_XOR_LONG, 32'h8000_1234, 6'h0, 1'b0, 11'h0);
        step(1'b1, 1'b1, ALO_OP_OR_STACK, 32'h0, 6'h0, 1'b0, 11'h0);
        step(1'b1, 1'b1, ALO_OP_XOR_WORD, 32'h0000_1234, 6'h0, 1'b0, 11'h0);
        // Run length boundaries, global space at its top end
        step(1'b1, 1'b1, ALO_OP_XOR_BITS, 32'h0, 6'h20, 1'b1, 11'h7e0);
        step(1'b1, 1'b1, ALO_OP_OR_BITS, 32'h0, 6'h01, 1'b1, 11'h005);
        // Random traffic, with clock-enable and idle gaps mixed in
        repeat (200) begin
            r = rnd();
            v = rnd();
            if (r[7:0] % 9 == 1) v = acc_m;
            step(r[11:9] != 0, r[14:12] != 0, alo_op_t'(r[7:0] % 9), v,
                 r[21:16], r[22], r[31:21]);
        end
        // Reset in mid-run clears everything
        resetn = 1'b0;
        reset_model();
        step(1'b1, 1'b1, ALO_OP_LOAD, 32'h5, 6'h0, 1'b0, 11'h0);
        resetn = 1'b1;
        step(1'b1, 1'b1, ALO_OP_OR_WORD, 32'h0, 6'h0, 1'b0, 11'h0);
        summarize();
    end
endmodule
